// ---- eee_mmd_map.svh ----
// Register map constants for the EEE and time-sync MMD register bank
`ifndef EEE_MMD_MAP_SVH
`define EEE_MMD_MAP_SVH

// ==========================================
// Clause 22 access registers
`define EEE_REG_MMD_CTRL      5'h0D
`define EEE_REG_MMD_DATA      5'h0E

// ==========================================
// MMD control field layout
`define EEE_CTRL_FUNC_HI      15
`define EEE_CTRL_FUNC_LO      14
`define EEE_CTRL_DEVAD_HI     4
`define EEE_FUNC_ADDR         2'h0
`define EEE_FUNC_DATA         2'h1
`define EEE_FUNC_INC_RW       2'h2
`define EEE_FUNC_INC_W        2'h3

// ==========================================
// Device addresses
`define EEE_DEV_PMA           5'h01
`define EEE_DEV_PCS           5'h03
`define EEE_DEV_PHYXS         5'h04
`define EEE_DEV_AN            5'h07

// ==========================================
// Register addresses inside devices
`define EEE_ADR_STATUS1       16'h0001
`define EEE_ADR_EEE_CAP       16'h0014
`define EEE_ADR_WAKE_ERR      16'h0016
`define EEE_ADR_ADV           16'h003C
`define EEE_ADR_LP_ADV        16'h003D
`define EEE_ADR_TS_BASE       16'h0708
`define EEE_ADR_TS_LAST       16'h0710

// ==========================================
// Field positions
`define EEE_BIT_PMA_LINK      2
`define EEE_BIT_PCS_LINK      2
`define EEE_BIT_RX_LPI_NOW    8
`define EEE_BIT_TX_LPI_NOW    9
`define EEE_BIT_RX_LPI_SEEN   10
`define EEE_BIT_TX_LPI_SEEN   11
`define EEE_BIT_GIG           2
`define EEE_BIT_FAST          1
`define EEE_BIT_TS_TX         1
`define EEE_BIT_TS_RX         0

// ==========================================
// Reset values
`define EEE_RST_ADV           2'h0
`define EEE_RST_COUNT         16'h0000

`endif

// ---- eee_mmd_pkg.sv ----
// Types shared by the EEE and time-sync MMD register bank
package eee_mmd_pkg;

    // Live status from the PHY datapaths
    typedef struct packed {
        logic pma_link_up;
        logic pcs_link_up;
        logic tx_lpi_now;
        logic rx_lpi_now;
        logic wake_fault;
    } eee_status_type;

    // Time-sync delay words of one sublayer
    typedef struct packed {
        logic [1:0]  cap;
        logic [15:0] tx_max_lo;
        logic [15:0] tx_max_hi;
        logic [15:0] tx_min_lo;
        logic [15:0] tx_min_hi;
        logic [15:0] rx_max_lo;
        logic [15:0] rx_max_hi;
        logic [15:0] rx_min_lo;
        logic [15:0] rx_min_hi;
    } eee_tsync_type;

    typedef enum logic [1:0] {
        EEE_FN_ADDR,
        EEE_FN_DATA,
        EEE_FN_INC_RW,
        EEE_FN_INC_W
    } eee_func_type;

endpackage

// ---- eee_mmd_regs.sv ----
// EEE and time-sync MMD register bank behind clause 22 registers 13 and 14
//
// Function
// - Extended space reached only via registers 13/14
// - Time-sync words read zero while link down
// - PMA time-sync capability and delays at 1.180x
// - PCS time-sync capability and delays at 3.180x
// - PHY XS time-sync words at 4.180x
// - PMA link status bit 2, latch low
// - PCS bit 11 Tx LPI seen, latch high
// - PCS bit 10 Rx LPI seen, latch high
// - PCS bit 9 live Tx LPI
// - PCS bit 8 live Rx LPI
// - PCS link status bit 2, latch low
// - Eee_ability_word bits 2 and 1
// - 16-bit wake fault counter
// - Counter clears on read and reset
// - Faults counted during refresh or wakeup
// - Advertisement sent in next page
// - Advertisement bits 2,1 writable, default zero
// - Registers at 7.60, 7.61, 3.20, 3.22
// - Partner advertisement read-only, mirrored after AN
// - Capability bits 1/0; PCS delays low/high
`timescale 1ns/100ps
`include "eee_mmd_map.svh"

module eee_mmd_regs
    import eee_mmd_pkg::*;
(
    input  wire logic           REF_CLK,
    input  wire logic           RST_B,
    input  wire logic           SOFT_RST,
    input  wire logic [4:0]     REG_ADDR,
    input  wire logic           REG_WR,
    input  wire logic           REG_RD,
    input  wire logic [15:0]    REG_WDATA,
    output logic      [15:0]    REG_RDATA,
    input  wire eee_status_type STATUS,
    input  wire logic           LINK_UP,
    input  wire logic           GIG_EEE_CAPABLE,
    input  wire logic           FAST_EEE_CAPABLE,
    input  wire logic           AN_DONE,
    input  wire logic [1:0]     PARTNER_ADV,
    input  wire eee_tsync_type  TS_PMA,
    input  wire eee_tsync_type  TS_PCS,
    input  wire eee_tsync_type  TS_PHYXS,
    output logic      [1:0]     LOCAL_ADV
);

    // ==========================================
    // Access registers
    logic [15:0] ctrl_q;
    logic [15:0] addr_q;
    logic [15:0] rdata_q;
    logic [1:0]  adv_q;
    logic [1:0]  lp_adv_q;
    logic [15:0] wake_cnt_q;
    logic        pma_ll_q;
    logic        pcs_ll_q;
    logic        tx_lh_q;
    logic        rx_lh_q;

    eee_func_type func;
    wire  [4:0]   devad     = ctrl_q[`EEE_CTRL_DEVAD_HI:0];
    assign func             = eee_func_type'(ctrl_q[`EEE_CTRL_FUNC_HI:`EEE_CTRL_FUNC_LO]);

    wire          sel_ctrl  = REG_ADDR == `EEE_REG_MMD_CTRL;
    wire          sel_data  = REG_ADDR == `EEE_REG_MMD_DATA;
    wire          data_acc  = sel_data && func != EEE_FN_ADDR;
    wire          data_rd   = REG_RD && data_acc;
    wire          data_wr   = REG_WR && data_acc;
    wire          addr_inc  = (REG_RD && sel_data && func == EEE_FN_INC_RW) ||
                              (REG_WR && sel_data && func != EEE_FN_ADDR && func != EEE_FN_DATA);

    wire          hit_pma_st = devad == `EEE_DEV_PMA && addr_q == `EEE_ADR_STATUS1;
    wire          hit_pcs_st = devad == `EEE_DEV_PCS && addr_q == `EEE_ADR_STATUS1;
    wire          hit_cap    = devad == `EEE_DEV_PCS && addr_q == `EEE_ADR_EEE_CAP;
    wire          hit_wake   = devad == `EEE_DEV_PCS && addr_q == `EEE_ADR_WAKE_ERR;
    wire          hit_adv    = devad == `EEE_DEV_AN && addr_q == `EEE_ADR_ADV;
    wire          hit_lp     = devad == `EEE_DEV_AN && addr_q == `EEE_ADR_LP_ADV;
    wire          in_ts      = addr_q >= `EEE_ADR_TS_BASE && addr_q <= `EEE_ADR_TS_LAST;
    wire  [3:0]   ts_idx     = 4'(addr_q - `EEE_ADR_TS_BASE);

    // ==========================================
    // Time-sync word selection
    // sublayer word select
    eee_tsync_type ts_sel;
    assign ts_sel = devad == `EEE_DEV_PMA ? TS_PMA :
                    devad == `EEE_DEV_PCS ? TS_PCS : TS_PHYXS;
    wire          ts_dev = devad == `EEE_DEV_PMA || devad == `EEE_DEV_PCS || devad == `EEE_DEV_PHYXS;
    // PCS has high words at even addresses; others only odd
    wire          ts_hi_ok = devad == `EEE_DEV_PCS;
    logic [15:0]  ts_word;
    always_comb begin
        ts_word = 16'h0000;
        unique case (ts_idx)
            4'h0: ts_word = {14'h0000, ts_sel.cap};
            4'h1: ts_word = ts_sel.tx_max_lo;
            4'h2: ts_word = ts_hi_ok ? ts_sel.tx_max_hi : 16'h0000;
            4'h3: ts_word = ts_sel.tx_min_lo;
            4'h4: ts_word = ts_hi_ok ? ts_sel.tx_min_hi : 16'h0000;
            4'h5: ts_word = ts_sel.rx_max_lo;
            4'h6: ts_word = ts_hi_ok ? ts_sel.rx_max_hi : 16'h0000;
            4'h7: ts_word = ts_sel.rx_min_lo;
            4'h8: ts_word = ts_hi_ok ? ts_sel.rx_min_hi : 16'h0000;
            default: ts_word = 16'h0000;
        endcase
    end

    // ==========================================
    // Status words
    logic [15:0] pma_word;
    logic [15:0] pcs_word;
    logic [15:0] cap_word;
    always_comb begin
        pma_word = 16'h0000;
        pcs_word = 16'h0000;
        cap_word = 16'h0000;
        pma_word[`EEE_BIT_PMA_LINK]    = pma_ll_q;
        pcs_word[`EEE_BIT_PCS_LINK]    = pcs_ll_q;
        pcs_word[`EEE_BIT_TX_LPI_SEEN] = tx_lh_q;
        pcs_word[`EEE_BIT_RX_LPI_SEEN] = rx_lh_q;
        pcs_word[`EEE_BIT_TX_LPI_NOW]  = STATUS.tx_lpi_now;
        pcs_word[`EEE_BIT_RX_LPI_NOW]  = STATUS.rx_lpi_now;
        cap_word[`EEE_BIT_GIG]         = GIG_EEE_CAPABLE;
        cap_word[`EEE_BIT_FAST]        = FAST_EEE_CAPABLE;
    end

    logic [15:0] mmd_word;
    always_comb begin
        mmd_word = 16'h0000;
        if (in_ts && ts_dev) begin
            mmd_word = LINK_UP ? ts_word : 16'h0000;
        end else if (hit_pma_st) begin
            mmd_word = pma_word;
        end else if (hit_pcs_st) begin
            mmd_word = pcs_word;
        end else if (hit_cap) begin
            mmd_word = cap_word;
        end else if (hit_wake) begin
            mmd_word = wake_cnt_q;
        end else if (hit_adv) begin
            mmd_word = {13'h0000, adv_q, 1'b0};
        end else if (hit_lp) begin
            mmd_word = {13'h0000, lp_adv_q, 1'b0};
        end
    end

    wire [15:0] rd_mux = sel_ctrl ? ctrl_q :
                         sel_data ? (func == EEE_FN_ADDR ? addr_q : mmd_word) : 16'h0000;
    wire        rd_pma = data_rd && hit_pma_st;
    wire        rd_pcs = data_rd && hit_pcs_st;
    wire        rd_wk  = data_rd && hit_wake;

    // ==========================================
    // Access and advertisement registers
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q  <= 16'h0000;
            addr_q  <= 16'h0000;
            rdata_q <= 16'h0000;
            adv_q   <= `EEE_RST_ADV;
        end else if (SOFT_RST) begin
            ctrl_q  <= 16'h0000;
            addr_q  <= 16'h0000;
            rdata_q <= 16'h0000;
            adv_q   <= `EEE_RST_ADV;
        end else begin
            if (REG_RD) begin
                rdata_q <= rd_mux;
            end
            if (REG_WR && sel_ctrl) begin
                ctrl_q <= REG_WDATA;
            end
            if (REG_WR && sel_data && func == EEE_FN_ADDR) begin
                addr_q <= REG_WDATA;
            end else if (addr_inc) begin
                addr_q <= addr_q + 16'h0001;
            end
            // only bits 2 and 1 writable
            if (data_wr && hit_adv) begin
                adv_q <= REG_WDATA[`EEE_BIT_GIG:`EEE_BIT_FAST];
            end
        end
    end

    // ==========================================
    // Latched status and wake counter
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            pma_ll_q   <= 1'b0;
            pcs_ll_q   <= 1'b0;
            tx_lh_q    <= 1'b0;
            rx_lh_q    <= 1'b0;
            wake_cnt_q <= `EEE_RST_COUNT;
            lp_adv_q   <= 2'h0;
        end else if (SOFT_RST) begin
            pma_ll_q   <= 1'b0;
            pcs_ll_q   <= 1'b0;
            tx_lh_q    <= 1'b0;
            rx_lh_q    <= 1'b0;
            wake_cnt_q <= `EEE_RST_COUNT;
            lp_adv_q   <= 2'h0;
        end else begin
            // read re-arms latch to live value; new event wins
            pma_ll_q <= rd_pma ? STATUS.pma_link_up : (pma_ll_q & STATUS.pma_link_up);
            pcs_ll_q <= rd_pcs ? STATUS.pcs_link_up : (pcs_ll_q & STATUS.pcs_link_up);
            tx_lh_q  <= rd_pcs ? STATUS.tx_lpi_now : (tx_lh_q | STATUS.tx_lpi_now);
            rx_lh_q  <= rd_pcs ? STATUS.rx_lpi_now : (rx_lh_q | STATUS.rx_lpi_now);
            // count faults; refresh or wakeup fault
            // read clears, but a fault in that cycle counts 1
            if (rd_wk) begin
                wake_cnt_q <= {15'h0000, STATUS.wake_fault};
            end else if (STATUS.wake_fault && wake_cnt_q != 16'hFFFF) begin
                wake_cnt_q <= wake_cnt_q + 16'h0001;
            end
            if (AN_DONE) begin
                lp_adv_q <= PARTNER_ADV;
            end
        end
    end

    assign REG_RDATA = rdata_q;
    assign LOCAL_ADV = adv_q;

endmodule

// ---- eee_mmd_chk.sv ----
// Port checker of the EEE and time-sync MMD register bank
`timescale 1ns/100ps
`include "eee_mmd_map.svh"
module eee_mmd_chk
    import eee_mmd_pkg::*;
(
    input wire logic           REF_CLK,
    input wire logic           RST_B,
    input wire logic           SOFT_RST,
    input wire logic [4:0]     REG_ADDR,
    input wire logic           REG_WR,
    input wire logic           REG_RD,
    input wire logic [15:0]    REG_WDATA,
    input wire logic [15:0]    REG_RDATA,
    input wire eee_status_type STATUS,
    input wire logic           LINK_UP,
    input wire logic           GIG_EEE_CAPABLE,
    input wire logic           FAST_EEE_CAPABLE,
    input wire eee_tsync_type  TS_PCS,
    input wire logic [1:0]     LOCAL_ADV
);
    logic [4:0]  dev_q;
    logic [15:0] adr_q;
    logic [1:0]  fn_q;
    wire         wr13  = REG_WR && REG_ADDR == `EEE_REG_MMD_CTRL;
    wire         acc14 = (REG_WR || REG_RD) && REG_ADDR == `EEE_REG_MMD_DATA;
    wire         hit   = REG_RD && REG_ADDR == `EEE_REG_MMD_DATA && fn_q != `EEE_FUNC_ADDR;
    wire         inc   = acc14 && (fn_q == `EEE_FUNC_INC_RW || (fn_q == `EEE_FUNC_INC_W && REG_WR));
    wire         ld    = acc14 && REG_WR && fn_q == `EEE_FUNC_ADDR;

    // ==========================================
    // Shadow of the selected MMD location
    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            {fn_q, dev_q, adr_q} <= '0;
        end else if (SOFT_RST) begin
            {fn_q, dev_q, adr_q} <= '0;
        end else begin
            if (wr13)
                {fn_q, dev_q} <= {REG_WDATA[15:14], REG_WDATA[4:0]};
            if (ld)
                adr_q <= REG_WDATA;
            else if (inc)
                adr_q <= adr_q + 16'h0001;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    rdata_hold_a: assert property (!REG_RD && !SOFT_RST |=> $stable(REG_RDATA))
        else $error("read data moved without a read");
    unmapped_zero_a: assert property (REG_RD && !acc14 && !wr13 && REG_ADDR != `EEE_REG_MMD_CTRL
        |=> REG_RDATA == 16'h0000) else $error("undecoded register read not zero");
    adv_reset_a: assert property (SOFT_RST |=> LOCAL_ADV == 2'h0) else $error("advert not cleared");
    adv_cause_a: assert property (!SOFT_RST && !(acc14 && REG_WR) |=> $stable(LOCAL_ADV))
        else $error("advert changed without a write");
    ts_down_zero_a: assert property (hit && !LINK_UP && adr_q >= `EEE_ADR_TS_BASE && adr_q <= `EEE_ADR_TS_LAST
        |=> REG_RDATA == 16'h0000) else $error("time-sync word nonzero with link down");
    cap_word_a: assert property (hit && dev_q == `EEE_DEV_PCS && adr_q == `EEE_ADR_EEE_CAP
        |=> REG_RDATA == {13'h0000, $past(GIG_EEE_CAPABLE), $past(FAST_EEE_CAPABLE), 1'b0})
        else $error("capability word wrong");
    lpi_live_a: assert property (hit && dev_q == `EEE_DEV_PCS && adr_q == `EEE_ADR_STATUS1
        |=> REG_RDATA[9:8] == $past({STATUS.tx_lpi_now, STATUS.rx_lpi_now}) && (REG_RDATA & 16'hF0FB) == 16'h0000)
        else $error("live idle bits wrong");
    pma_reserved_a: assert property (hit && dev_q == `EEE_DEV_PMA && adr_q == `EEE_ADR_STATUS1
        |=> (REG_RDATA & 16'hFFFB) == 16'h0000) else $error("reserved status bits set");
    pcs_delay_a: assert property (hit && LINK_UP && dev_q == `EEE_DEV_PCS && adr_q == 16'h0709
        |=> REG_RDATA == $past(TS_PCS.tx_max_lo)) else $error("delay word wrong");

    cover property (hit && dev_q == `EEE_DEV_PCS);
    cover property (STATUS.wake_fault);
    cover property (hit && !LINK_UP && adr_q >= `EEE_ADR_TS_BASE);
endmodule

bind eee_mmd_regs eee_mmd_chk eee_mmd_chk_inst (.REF_CLK, .RST_B, .SOFT_RST, .REG_ADDR, .REG_WR, .REG_RD,
    .REG_WDATA, .REG_RDATA, .STATUS, .LINK_UP, .GIG_EEE_CAPABLE, .FAST_EEE_CAPABLE, .TS_PCS, .LOCAL_ADV);

// ---- eee_smc.sv ----
// Station management model making clause 22 accesses
`timescale 1ns/100ps
module eee_smc (
    input  wire logic        clk,
    output logic      [4:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [15:0] reg_wdata,
    input  wire logic [15:0] reg_rdata
);
    int gap = 0;
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = '0;

    task automatic acc(input logic [4:0] a, input logic w, input logic [15:0] wd, output logic [15:0] rv);
        repeat (gap) @(posedge clk);
        @(posedge clk);
        #1;
        {reg_addr, reg_wr, reg_rd, reg_wdata} = {a, w, !w, wd};
        @(posedge clk);
        #1;
        {reg_wr, reg_rd, reg_wdata} = {2'b00, ~wd};
        @(posedge clk);
        #1;
        rv = reg_rdata;
    endtask

    task automatic sel(input logic [4:0] dv, input logic [15:0] a, input logic [1:0] fn);
        logic [15:0] x;
        acc(5'h0D, 1'b1, {2'b00, 9'h000, dv}, x);
        acc(5'h0E, 1'b1, a, x);
        acc(5'h0D, 1'b1, {fn, 9'h000, dv}, x);
    endtask

    task automatic mmd(input logic [4:0] dv, input logic [15:0] a, input logic w, input logic [15:0] wd,
                       output logic [15:0] rv);
        sel(dv, a, 2'h1);
        acc(5'h0E, w, wd, rv);
    endtask
endmodule

// ---- tb.sv ----
// Self-checking bench of the EEE and time-sync MMD register bank
`timescale 1ns/100ps
module tb;
    import eee_mmd_pkg::*;
    logic           clk, rst_b, soft_rst, link_up, gig, fast, an_done, reg_wr, reg_rd;
    logic [4:0]     reg_addr;
    logic [15:0]    reg_wdata, rdata, d;
    logic [1:0]     partner_adv, local_adv;
    eee_status_type st;
    eee_tsync_type  ts_pma, ts_pcs, ts_phyxs;
    int             num_errors = 0;
    int             total_checks = 0;

    eee_mmd_regs eee_mmd_regs_inst (.REF_CLK(clk), .RST_B(rst_b), .SOFT_RST(soft_rst), .REG_ADDR(reg_addr),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata), .REG_RDATA(rdata), .STATUS(st),
        .LINK_UP(link_up), .GIG_EEE_CAPABLE(gig), .FAST_EEE_CAPABLE(fast), .AN_DONE(an_done),
        .PARTNER_ADV(partner_adv), .TS_PMA(ts_pma), .TS_PCS(ts_pcs), .TS_PHYXS(ts_phyxs), .LOCAL_ADV(local_adv));
    eee_smc eee_smc_inst (.clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(rdata));

    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [4:0] dv, input logic [15:0] a, input logic [15:0] exp);
        eee_smc_inst.mmd(dv, a, 1'b0, 16'h0000, d);
        chk(d, exp);
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic t_regs;
        rd(5'h07, 16'h003C, 16'h0000);
        chk({14'h0000, local_adv}, 16'h0000);
        eee_smc_inst.mmd(5'h07, 16'h003C, 1'b1, 16'hFFFF, d);
        rd(5'h07, 16'h003C, 16'h0006);
        chk({14'h0000, local_adv}, 16'h0003);
        eee_smc_inst.mmd(5'h07, 16'h003D, 1'b1, 16'hFFFF, d);
        rd(5'h07, 16'h003D, 16'h0000);
        {an_done, partner_adv, gig} = 4'b1101;
        rd(5'h07, 16'h003D, 16'h0004);
        rd(5'h03, 16'h0014, 16'h0004);
        {gig, fast} = 2'b01;
        rd(5'h03, 16'h0014, 16'h0002);
        rd(5'h03, 16'h0015, 16'h0000);
        eee_smc_inst.acc(5'h05, 1'b0, 16'h0000, d);
        chk(d, 16'h0000);
        $display("register test done");
    endtask

    task automatic t_status;
        st[4:3] = 2'b11;
        for (int k = 0; k < 2; k++) begin
            if (k) begin
                st[4:3] = 2'b00;
                tick();
                st[4:3] = 2'b11;
            end
            rd(5'h01, 16'h0001, 16'h0000);
            rd(5'h03, 16'h0001, 16'h0000);
            rd(5'h01, 16'h0001, 16'h0004);
            rd(5'h03, 16'h0001, 16'h0004);
        end
        st.tx_lpi_now = 1'b1;
        tick();
        st.tx_lpi_now = 1'b0;
        rd(5'h03, 16'h0001, 16'h0804);
        rd(5'h03, 16'h0001, 16'h0004);
        st[2:1] = 2'b11;
        rd(5'h03, 16'h0001, 16'h0F04);
        st[2:1] = 2'b00;
        $display("status test done");
    endtask

    task automatic t_wake;
        repeat (3) begin
            st.wake_fault = 1'b1;
            tick();
            st.wake_fault = 1'b0;
            tick();
        end
        rd(5'h03, 16'h0016, 16'h0003);
        rd(5'h03, 16'h0016, 16'h0000);
        st.wake_fault = 1'b1;
        tick();
        {st.wake_fault, soft_rst} = 2'b01;
        tick();
        soft_rst = 1'b0;
        rd(5'h03, 16'h0016, 16'h0000);
        rd(5'h07, 16'h003C, 16'h0000);
        $display("wake test done");
    endtask

    task automatic t_tsync;
        {link_up, eee_smc_inst.gap} = {1'b1, 32'd2};
        eee_smc_inst.sel(5'h03, 16'h0708, 2'h2);
        for (int i = 0; i < 9; i++) begin
            eee_smc_inst.acc(5'h0E, 1'b0, 16'h0000, d);
            chk(d, i ? {i[3:0], 12'h000} : 16'h0002);
        end
        eee_smc_inst.gap = 0;
        rd(5'h01, 16'h0708, 16'h0001);
        rd(5'h01, 16'h0709, 16'hA001);
        rd(5'h01, 16'h070A, 16'h0000);
        rd(5'h04, 16'h0708, 16'h0003);
        rd(5'h04, 16'h070F, 16'hE007);
        link_up = 1'b0;
        rd(5'h03, 16'h0709, 16'h0000);
        $display("time-sync test done");
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #300000;
        num_errors++;
        conclude();
    end
    initial begin
        {rst_b, soft_rst, link_up, gig, fast, an_done, partner_adv, st} = '0;
        ts_pma = {2'h1, 128'hA001_A002_A003_A004_A005_A006_A007_A008};
        ts_pcs = {2'h2, 128'h1000_2000_3000_4000_5000_6000_7000_8000};
        ts_phyxs = {2'h3, 128'hE001_E002_E003_E004_E005_E006_E007_E008};
        repeat (6) @(posedge clk);
        #1;
        rst_b = 1'b1;
        t_regs();
        t_status();
        t_wake();
        t_tsync();
        conclude();
    end
endmodule
